/* dv/alarm_and_gate_calc_config_test.sv */
`default_nettype none
module alarm_and_gate_calc_config_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int W = 12;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic reg_sel = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata_q;
  // strobes: 5:0 samples, 13:6 events, 15:14 calc done
  logic [15:0] stb = 16'h0000;
  logic [W-1:0] sd = 12'h000;
  logic [7:0] alert;
  logic [W-1:0] avg [4];
  logic [3:0] avg_v;
  logic [1:0] recalc, tsrc, in_ld, out_ld, psrc1, psrc2;
  logic [W-1:0] dac1, dac2;
  logic [31:0] rnd = 32'h4C4B;
  logic [15:0] w;
  logic [11:0] e2;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  int sum;
  alarm_and_gate_calc_config #(.W(W)) u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .ch1_current_alert_window_sel(alert[0]), .ch1_current_alert_en(alert[1]),
    .ch1_temp_alert_window_sel(alert[2]), .ch1_temp_alert_en(alert[3]),
    .ch2_current_alert_window_sel(alert[4]), .ch2_current_alert_en(alert[5]),
    .ch2_temp_alert_window_sel(alert[6]), .ch2_temp_alert_en(alert[7]),
    .ext_temp1_valid(stb[0]), .ext_temp1(sd), .ext_temp2_valid(stb[1]), .ext_temp2(sd),
    .die_temp_valid(stb[2]), .die_temp(sd), .drain1_valid(stb[3]), .drain1(sd),
    .drain2_valid(stb[4]), .drain2(sd), .aux_analog_input_valid(stb[5]), .aux_analog_input(sd),
    .ch1_temp_avg(avg[0]), .ch1_temp_avg_valid(avg_v[0]), .ch1_param_avg(avg[1]),
    .ch1_param_avg_valid(avg_v[1]), .ch2_temp_avg(avg[2]), .ch2_temp_avg_valid(avg_v[2]),
    .ch2_param_avg(avg[3]), .ch2_param_avg_valid(avg_v[3]),
    .ch1_temp_changed(stb[6]), .ch2_temp_changed(stb[7]), .ch1_param_changed(stb[8]),
    .ch2_param_changed(stb[9]), .ch1_param_write(stb[10]), .ch2_param_write(stb[11]),
    .ch1_vset_write(stb[12]), .ch2_vset_write(stb[13]), .ch1_recalc_q(recalc[0]), .ch2_recalc_q(recalc[1]),
    .ch1_temp_source_sel(tsrc[0]), .ch2_temp_source_sel(tsrc[1]),
    .ch1_param_source_sel(psrc1), .ch2_param_source_sel(psrc2),
    .ch1_calc_done(stb[14]), .ch2_calc_done(stb[15]), .ch1_gate_voltage_result(sd),
    .ch2_gate_voltage_result(sd), .ch1_dac_data_q(dac1), .ch2_dac_data_q(dac2),
    .ch1_dac_in_load_q(in_ld[0]), .ch1_dac_out_load_q(out_ld[0]),
    .ch2_dac_in_load_q(in_ld[1]), .ch2_dac_out_load_q(out_ld[1])
  );
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [11:0] track(input logic [11:0] a, input logic [11:0] s, input int code,
                                        input logic q);
    int d;
    int lim;
    d = int'(s) - int'(a);
    lim = (1 << code) - 1;
    if (code != 0 && d > lim) d = lim;
    if (code != 0 && d < -lim) d = -lim;
    return 12'(int'(a) + (q ? (d >>> 2) : (d >>> 4)));
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic s, input logic [15:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_sel = s;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic s, input logic [15:0] e);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_sel = s;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk("readback", e, reg_rdata_q);
  endtask
  // one-cycle strobe; data rides on the shared sample and result bus
  task automatic pulse(input int i, input logic [11:0] v);
    @(negedge ref_clk);
    stb[i] = 1'b1;
    sd = v;
    @(negedge ref_clk);
    stb = 16'h0000;
  endtask
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  // hang guard, well above the roughly 500 cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop;
    end
  end
  // ==========================================================
  // tests
  initial begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    rd(1'b0, 16'h0000);
    rd(1'b1, 16'h0000);
    chk("alerts", 16'h0000, {8'h00, alert});
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      wr(1'b0, rnd[15:0]);
      chk("alerts", {8'h00, rnd[7:0]}, {8'h00, alert});
      rd(1'b0, {8'h00, rnd[7:0]});
      rnd = lfsr(rnd);
      w = rnd[15:0];
      w[1] = w[1] | w[0];
      w[7] = w[7] | w[6];
      wr(1'b1, w);
      chk("sources", {10'h000, w[8], w[2], w[7:6], w[1:0]}, {10'h000, tsrc, psrc2, psrc1});
      rd(1'b1, {4'h0, w[11:0]});
    end
    $display("register test done");
    // a low clock enable must swallow both a register write and a trigger event
    wr(1'b0, 16'h0055);
    ce = 1'b0;
    wr(1'b0, 16'h00AA);
    pulse(12, 12'h000);
    chk("frozen alerts", 16'h0055, {8'h00, alert});
    chk("frozen recalc", 16'h0000, 16'(recalc));
    ce = 1'b1;
    $display("clock enable test done");
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 0; k < 8; k++) begin
        w = 16'h0000;
        w[ch ? cfg_pkg::GC_CH2_TTRIG : cfg_pkg::GC_CH1_TTRIG] = k[0];
        w[ch ? cfg_pkg::GC_CH2_PTRIG : cfg_pkg::GC_CH1_PTRIG] = k[1];
        w[ch ? 7 : 1] = k[2];
        wr(1'b1, w);
        pulse(6 + ch, 12'h000);
        chk("temp trigger", 16'(k[0]) << ch, 16'(recalc));
        pulse(8 + ch, 12'h000);
        chk("sample trigger", 16'(k[1] & k[2]) << ch, 16'(recalc));
        pulse(10 + ch, 12'h000);
        chk("param trigger", 16'(k[1] & ~k[2]) << ch, 16'(recalc));
        pulse(12 + ch, 12'h000);
        chk("vset trigger", 16'h0001 << ch, 16'(recalc));
      end
      for (int ld = 0; ld < 2; ld++) begin
        w = 16'h0000;
        w[ch ? cfg_pkg::GC_CH2_LOAD : cfg_pkg::GC_CH1_LOAD] = ld[0];
        wr(1'b1, w);
        rnd = lfsr(rnd);
        pulse(14 + ch, rnd[11:0]);
        chk("dac data", 16'(rnd[11:0]), 16'(ch ? dac2 : dac1));
        chk("input load", 16'h0001 << ch, 16'(in_ld));
        chk("output load", 16'(!ld[0]) << ch, 16'(out_ld));
      end
    end
    $display("trigger and result test done");
    // ch1 temperature from the die sensor, ch1 parameter from drain, ch2 parameter from aux
    wr(1'b1, 16'h00C6);
    wr(1'b0, 16'h0F00);
    sum = 0;
    e2 = 12'h3E8;
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      sum += int'(rnd[11:0]);
      pulse(2, rnd[11:0]);
      pulse(5, rnd[11:0]);
      pulse(3, rnd[11:0]);
      pulse(1, e2);
      if (i == 14) chk("early valid", 16'h0000, 16'(avg_v));
    end
    chk("ch1 temp avg", 16'(sum / 16), 16'(avg[0]));
    chk("ch1 param avg", 16'(sum / 16), 16'(avg[1]));
    chk("ch2 param avg", 16'(sum / 16), 16'(avg[3]));
    chk("valid", 16'h000F, 16'(avg_v));
    for (int k = 0; k < 16; k++) begin
      wr(1'b1, {k[0], k[3:1], 12'h002});
      rnd = lfsr(rnd);
      pulse(1, rnd[11:0]);
      e2 = track(e2, rnd[11:0], k[3:1], k[0]);
      chk("ch2 tracking", 16'(e2), 16'(avg[2]));
    end
    wr(1'b0, 16'h0000);
    @(negedge ref_clk);
    chk("valid off", 16'h0000, 16'(avg_v));
    $display("filter test done");
    report_and_stop;
  end
endmodule
`default_nettype wire

/* dv/alarm_cfg_props.sv */
`default_nettype none
module alarm_cfg_props #(
  parameter int W = 12
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_sel,
  input wire logic [cfg_pkg::REG_W-1:0] reg_wdata,
  input wire logic [cfg_pkg::REG_W-1:0] reg_rdata_q,
  input wire logic [1:0] ch2_param_source_sel,
  input wire logic ch1_temp_changed,
  input wire logic ch1_recalc_q,
  input wire logic ch1_calc_done,
  input wire logic [W-1:0] ch1_gate_voltage_result,
  input wire logic [W-1:0] ch1_dac_data_q,
  input wire logic ch1_dac_in_load_q,
  input wire logic ch1_dac_out_load_q,
  input wire logic ch2_calc_done,
  input wire logic ch2_dac_out_load_q,
  input wire logic ch1_temp_avg_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // shadow of the gate register and the ch1 filter enable bit, since no output port shows the bits the checks use
  logic [15:0] gc_q;
  logic af_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gc_q <= 16'h0000;
      af_q <= 1'b0;
    end else if (ce && reg_wr) begin
      if (reg_sel == cfg_pkg::REG_GATE_CALC) begin
        gc_q <= reg_wdata;
      end else begin
        af_q <= reg_wdata[cfg_pkg::AF_FILT_LSB];
      end
    end
  end
  // ==========================================================
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_rd_alarm;
    ce && reg_rd && reg_sel == cfg_pkg::REG_ALARM_FILTER;
  endsequence
  sequence s_rd_gate;
    ce && reg_rd && reg_sel == cfg_pkg::REG_GATE_CALC;
  endsequence
  sequence s_done1;
    ce && ch1_calc_done;
  endsequence
  chk_read_alarm_zero: assert property (s_rd_alarm |=> reg_rdata_q[15:8] == 8'h00)
    else $error("alarm readback shows write-only or unused bits");
  chk_read_gate_zero: assert property (s_rd_gate |=> reg_rdata_q[15:12] == 4'h0)
    else $error("gate readback shows write-only bits");
  chk_rdata_holds: assert property (!(ce && reg_rd) |=> $stable(reg_rdata_q))
    else $error("readback changed without a read");
  chk_source_follows: assert property (ce && reg_wr && reg_sel == cfg_pkg::REG_GATE_CALC
    |=> ch2_param_source_sel == $past(reg_wdata[7:6])) else $error("ch2 source select not written");
  chk_temp_trigger: assert property (ce && ch1_temp_changed && gc_q[4] |=> ch1_recalc_q)
    else $error("ch1 temperature event did not request recalculation");
  chk_result_capture: assert property (s_done1 |=> ch1_dac_in_load_q
    && ch1_dac_data_q == $past(ch1_gate_voltage_result)) else $error("ch1 result not captured");
  chk_ch1_out_load: assert property (s_done1 |=> ch1_dac_out_load_q == !$past(gc_q[5]))
    else $error("ch1 output load wrong");
  chk_ch2_out_load: assert property (ce && ch2_calc_done |=> ch2_dac_out_load_q == !$past(gc_q[11]))
    else $error("ch2 output load wrong");
  chk_filter_off: assert property (ce && !af_q |=> !ch1_temp_avg_valid)
    else $error("ch1 temperature average valid while filter disabled");
endmodule
bind alarm_and_gate_calc_config alarm_cfg_props #(.W(W)) u_props (
  .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel),
  .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .ch2_param_source_sel(ch2_param_source_sel),
  .ch1_temp_changed(ch1_temp_changed), .ch1_recalc_q(ch1_recalc_q), .ch1_calc_done(ch1_calc_done),
  .ch1_gate_voltage_result(ch1_gate_voltage_result), .ch1_dac_data_q(ch1_dac_data_q),
  .ch1_dac_in_load_q(ch1_dac_in_load_q), .ch1_dac_out_load_q(ch1_dac_out_load_q),
  .ch2_calc_done(ch2_calc_done), .ch2_dac_out_load_q(ch2_dac_out_load_q),
  .ch1_temp_avg_valid(ch1_temp_avg_valid)
);
`default_nettype wire

/* shared/cfg_pkg.sv */
`default_nettype none
package cfg_pkg;
  // ==========================================================
  // register selection on the host access port
  localparam logic REG_ALARM_FILTER = 1'h0;
  localparam logic REG_GATE_CALC = 1'h1;
  localparam int REG_W = 16;
  // ==========================================================
  // alarm-filter configuration fields
  localparam int AF_CH1_CUR_WIN = 0;
  localparam int AF_CH1_CUR_EN = 1;
  localparam int AF_CH1_TEMP_WIN = 2;
  localparam int AF_CH1_TEMP_EN = 3;
  localparam int AF_CH2_CUR_WIN = 4;
  localparam int AF_CH2_CUR_EN = 5;
  localparam int AF_CH2_TEMP_WIN = 6;
  localparam int AF_CH2_TEMP_EN = 7;
  localparam int AF_FILT_LSB = 8;
  localparam int AF_FILT_W = 4;
  localparam logic [7:0] AF_ALERT_RESET = 8'h00;
  localparam logic [3:0] AF_FILT_RESET = 4'h0;
  // ==========================================================
  // gate-calculation configuration fields
  localparam int GC_CH1_SRC_LSB = 0;
  localparam int GC_CH1_TSRC = 2;
  localparam int GC_CH1_PTRIG = 3;
  localparam int GC_CH1_TTRIG = 4;
  localparam int GC_CH1_LOAD = 5;
  localparam int GC_CH2_SRC_LSB = 6;
  localparam int GC_CH2_TSRC = 8;
  localparam int GC_CH2_PTRIG = 9;
  localparam int GC_CH2_TTRIG = 10;
  localparam int GC_CH2_LOAD = 11;
  localparam int GC_CLAMP_LSB = 12;
  localparam int GC_EQ = 15;
  localparam logic [11:0] GC_RW_RESET = 12'h000;
  localparam logic [2:0] GC_CLAMP_RESET = 3'h0;
  localparam logic GC_EQ_RESET = 1'h0;
  // ==========================================================
  // parameter source codes, 01 is reserved
  localparam logic [1:0] SRC_STORED = 2'h0;
  localparam logic [1:0] SRC_RESERVED = 2'h1;
  localparam logic [1:0] SRC_DRAIN = 2'h2;
  localparam logic [1:0] SRC_AUX = 2'h3;
  // ==========================================================
  // averaging
  localparam int INIT_SAMPLES = 16;
  localparam int SHIFT_SIXTEENTH = 4;
  localparam int SHIFT_QUARTER = 2;
  localparam int SAMPLE_W = 12;
endpackage
`default_nettype wire

/* verilog/alarm_and_gate_calc_config.sv */
`default_nettype none
module alarm_and_gate_calc_config #(
  parameter int W = cfg_pkg::SAMPLE_W
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  // ==========================================================
  // host register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_sel,
  input wire logic [cfg_pkg::REG_W-1:0] reg_wdata,
  output logic [cfg_pkg::REG_W-1:0] reg_rdata_q,
  // ==========================================================
  // alert configuration to the comparators
  output logic ch1_current_alert_en,
  output logic ch1_current_alert_window_sel,
  output logic ch1_temp_alert_en,
  output logic ch1_temp_alert_window_sel,
  output logic ch2_current_alert_en,
  output logic ch2_current_alert_window_sel,
  output logic ch2_temp_alert_en,
  output logic ch2_temp_alert_window_sel,
  // ==========================================================
  // measurement samples, one-cycle valid strobes
  input wire logic ext_temp1_valid,
  input wire logic [W-1:0] ext_temp1,
  input wire logic ext_temp2_valid,
  input wire logic [W-1:0] ext_temp2,
  input wire logic die_temp_valid,
  input wire logic [W-1:0] die_temp,
  input wire logic drain1_valid,
  input wire logic [W-1:0] drain1,
  input wire logic drain2_valid,
  input wire logic [W-1:0] drain2,
  input wire logic aux_analog_input_valid,
  input wire logic [W-1:0] aux_analog_input,
  // ==========================================================
  // filtered values
  output logic [W-1:0] ch1_temp_avg,
  output logic ch1_temp_avg_valid,
  output logic [W-1:0] ch1_param_avg,
  output logic ch1_param_avg_valid,
  output logic [W-1:0] ch2_temp_avg,
  output logic ch2_temp_avg_valid,
  output logic [W-1:0] ch2_param_avg,
  output logic ch2_param_avg_valid,
  // ==========================================================
  // recalculation triggering
  input wire logic ch1_temp_changed,
  input wire logic ch2_temp_changed,
  input wire logic ch1_param_changed,
  input wire logic ch2_param_changed,
  input wire logic ch1_param_write,
  input wire logic ch2_param_write,
  input wire logic ch1_vset_write,
  input wire logic ch2_vset_write,
  output logic ch1_recalc_q,
  output logic ch2_recalc_q,
  output logic ch1_temp_source_sel,
  output logic ch2_temp_source_sel,
  output logic [1:0] ch1_param_source_sel,
  output logic [1:0] ch2_param_source_sel,
  // ==========================================================
  // gate result routing to the converter registers
  input wire logic ch1_calc_done,
  input wire logic ch2_calc_done,
  input wire logic [W-1:0] ch1_gate_voltage_result,
  input wire logic [W-1:0] ch2_gate_voltage_result,
  output logic [W-1:0] ch1_dac_data_q,
  output logic [W-1:0] ch2_dac_data_q,
  output logic ch1_dac_in_load_q,
  output logic ch1_dac_out_load_q,
  output logic ch2_dac_in_load_q,
  output logic ch2_dac_out_load_q
);
  // ==========================================================
  // source decoding shared by both channels
  function automatic logic [W:0] param_sample(
    input logic [1:0] src,
    input logic drain_v,
    input logic [W-1:0] drain,
    input logic aux_v,
    input logic [W-1:0] aux
  );
    // the reserved code feeds nothing, as the stored value does
    if (src == cfg_pkg::SRC_DRAIN) begin
      return {drain_v, drain};
    end else if (src == cfg_pkg::SRC_AUX) begin
      return {aux_v, aux};
    end else begin
      return {1'b0, {W{1'b0}}};
    end
  endfunction

  function automatic logic recalc(
    input logic ttrig,
    input logic ptrig,
    input logic [1:0] src,
    input logic temp_chg,
    input logic param_chg,
    input logic param_wr,
    input logic vset_wr
  );
    logic from_param;
    // a stored-value source retriggers on register writes, sampled ones on sample changes
    from_param = (src == cfg_pkg::SRC_STORED) ? param_wr : (src[1] & param_chg);
    return (ttrig & temp_chg) | (ptrig & from_param) | vset_wr;
  endfunction

  // ==========================================================
  // configuration registers
  logic [7:0] alert_q, alert_d;
  logic [cfg_pkg::AF_FILT_W-1:0] filt_q, filt_d;
  logic [11:0] gc_q, gc_d;
  logic [2:0] clamp_q, clamp_d;
  logic eq_q, eq_d;
  logic [cfg_pkg::REG_W-1:0] rdata_d;

  always_comb begin
    alert_d = alert_q;
    filt_d = filt_q;
    gc_d = gc_q;
    clamp_d = clamp_q;
    eq_d = eq_q;
    rdata_d = reg_rdata_q;
    if (reg_wr) begin
      if (reg_sel == cfg_pkg::REG_ALARM_FILTER) begin
        // bits 15:12 have no storage, so a write there has no effect
        alert_d = reg_wdata[7:0];
        filt_d = reg_wdata[cfg_pkg::AF_FILT_LSB +: cfg_pkg::AF_FILT_W];
      end else begin
        gc_d = reg_wdata[11:0];
        clamp_d = reg_wdata[cfg_pkg::GC_CLAMP_LSB +: 3];
        eq_d = reg_wdata[cfg_pkg::GC_EQ];
      end
    end
    // write-only bits are left out of the readback on purpose
    if (reg_rd) begin
      if (reg_sel == cfg_pkg::REG_ALARM_FILTER) begin
        rdata_d = {8'h00, alert_q};
      end else begin
        rdata_d = {4'h0, gc_q};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      alert_q <= cfg_pkg::AF_ALERT_RESET;
      filt_q <= cfg_pkg::AF_FILT_RESET;
      gc_q <= cfg_pkg::GC_RW_RESET;
      clamp_q <= cfg_pkg::GC_CLAMP_RESET;
      eq_q <= cfg_pkg::GC_EQ_RESET;
      reg_rdata_q <= 16'h0000;
    end else if (ce) begin
      alert_q <= alert_d;
      filt_q <= filt_d;
      gc_q <= gc_d;
      clamp_q <= clamp_d;
      eq_q <= eq_d;
      reg_rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // configuration outputs
  assign ch1_current_alert_en = alert_q[cfg_pkg::AF_CH1_CUR_EN];
  assign ch1_current_alert_window_sel = alert_q[cfg_pkg::AF_CH1_CUR_WIN];
  assign ch1_temp_alert_en = alert_q[cfg_pkg::AF_CH1_TEMP_EN];
  assign ch1_temp_alert_window_sel = alert_q[cfg_pkg::AF_CH1_TEMP_WIN];
  assign ch2_current_alert_en = alert_q[cfg_pkg::AF_CH2_CUR_EN];
  assign ch2_current_alert_window_sel = alert_q[cfg_pkg::AF_CH2_CUR_WIN];
  assign ch2_temp_alert_en = alert_q[cfg_pkg::AF_CH2_TEMP_EN];
  assign ch2_temp_alert_window_sel = alert_q[cfg_pkg::AF_CH2_TEMP_WIN];
  assign ch1_temp_source_sel = gc_q[cfg_pkg::GC_CH1_TSRC];
  assign ch2_temp_source_sel = gc_q[cfg_pkg::GC_CH2_TSRC];
  assign ch1_param_source_sel = gc_q[cfg_pkg::GC_CH1_SRC_LSB +: 2];
  assign ch2_param_source_sel = gc_q[cfg_pkg::GC_CH2_SRC_LSB +: 2];

  // ==========================================================
  // averaging filters: 0 ch1 temp, 1 ch1 param, 2 ch2 temp, 3 ch2 param
  logic [3:0] f_valid;
  logic [W-1:0] f_sample [4];
  logic [W-1:0] f_avg [4];
  logic [3:0] f_avg_valid;
  logic [W:0] p1_smp;
  logic [W:0] p2_smp;

  always_comb begin
    p1_smp = param_sample(ch1_param_source_sel, drain1_valid, drain1, aux_analog_input_valid, aux_analog_input);
    p2_smp = param_sample(ch2_param_source_sel, drain2_valid, drain2, aux_analog_input_valid, aux_analog_input);
    // temperature filters follow the selected sensor
    if (ch1_temp_source_sel) begin
      f_valid[0] = die_temp_valid;
      f_sample[0] = die_temp;
    end else begin
      f_valid[0] = ext_temp1_valid;
      f_sample[0] = ext_temp1;
    end
    if (ch2_temp_source_sel) begin
      f_valid[2] = die_temp_valid;
      f_sample[2] = die_temp;
    end else begin
      f_valid[2] = ext_temp2_valid;
      f_sample[2] = ext_temp2;
    end
    f_valid[1] = p1_smp[W];
    f_sample[1] = p1_smp[W-1:0];
    f_valid[3] = p2_smp[W];
    f_sample[3] = p2_smp[W-1:0];
  end

  // only the ch2 temperature filter has its equation and clamp programmable here
  for (genvar i = 0; i < 4; i++) begin : g_filt
    track_avg #(
      .W(W),
      .N(cfg_pkg::INIT_SAMPLES)
    ) u_avg (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .ce(ce),
      .enable(filt_q[i]),
      .sample_valid(f_valid[i]),
      .sample(f_sample[i]),
      .quarter_sel((i == 2) ? eq_q : 1'b0),
      .clamp_code((i == 2) ? clamp_q : 3'h0),
      .avg_q(f_avg[i]),
      .avg_valid_q(f_avg_valid[i])
    );
  end

  assign ch1_temp_avg = f_avg[0];
  assign ch1_temp_avg_valid = f_avg_valid[0];
  assign ch1_param_avg = f_avg[1];
  assign ch1_param_avg_valid = f_avg_valid[1];
  assign ch2_temp_avg = f_avg[2];
  assign ch2_temp_avg_valid = f_avg_valid[2];
  assign ch2_param_avg = f_avg[3];
  assign ch2_param_avg_valid = f_avg_valid[3];

  // ==========================================================
  // recalculation requests and result routing
  logic ch1_recalc_d, ch2_recalc_d;
  logic [W-1:0] ch1_dac_d, ch2_dac_d;
  logic ch1_in_d, ch1_out_d, ch2_in_d, ch2_out_d;

  always_comb begin
    ch1_recalc_d = recalc(gc_q[cfg_pkg::GC_CH1_TTRIG], gc_q[cfg_pkg::GC_CH1_PTRIG], ch1_param_source_sel,
                          ch1_temp_changed, ch1_param_changed, ch1_param_write, ch1_vset_write);
    ch2_recalc_d = recalc(gc_q[cfg_pkg::GC_CH2_TTRIG], gc_q[cfg_pkg::GC_CH2_PTRIG], ch2_param_source_sel,
                          ch2_temp_changed, ch2_param_changed, ch2_param_write, ch2_vset_write);
    ch1_dac_d = ch1_calc_done ? ch1_gate_voltage_result : ch1_dac_data_q;
    ch2_dac_d = ch2_calc_done ? ch2_gate_voltage_result : ch2_dac_data_q;
    ch1_in_d = ch1_calc_done;
    ch2_in_d = ch2_calc_done;
    // output register follows only when the channel is not held for a later load
    ch1_out_d = ch1_calc_done & ~gc_q[cfg_pkg::GC_CH1_LOAD];
    ch2_out_d = ch2_calc_done & ~gc_q[cfg_pkg::GC_CH2_LOAD];
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ch1_recalc_q <= 1'b0;
      ch2_recalc_q <= 1'b0;
      ch1_dac_data_q <= '0;
      ch2_dac_data_q <= '0;
      ch1_dac_in_load_q <= 1'b0;
      ch1_dac_out_load_q <= 1'b0;
      ch2_dac_in_load_q <= 1'b0;
      ch2_dac_out_load_q <= 1'b0;
    end else if (ce) begin
      ch1_recalc_q <= ch1_recalc_d;
      ch2_recalc_q <= ch2_recalc_d;
      ch1_dac_data_q <= ch1_dac_d;
      ch2_dac_data_q <= ch2_dac_d;
      ch1_dac_in_load_q <= ch1_in_d;
      ch1_dac_out_load_q <= ch1_out_d;
      ch2_dac_in_load_q <= ch2_in_d;
      ch2_dac_out_load_q <= ch2_out_d;
    end
  end
endmodule
`default_nettype wire

/* verilog/track_avg.sv */
`default_nettype none
// ==========================================================
// one averaging filter: block average of the first samples, then tracking
module track_avg #(
  parameter int W = cfg_pkg::SAMPLE_W,
  parameter int N = cfg_pkg::INIT_SAMPLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic enable,
  input wire logic sample_valid,
  input wire logic [W-1:0] sample,
  input wire logic quarter_sel,
  input wire logic [2:0] clamp_code,
  output logic [W-1:0] avg_q,
  output logic avg_valid_q
);
  localparam int CW = $clog2(N) + 1;
  localparam int SW = W + $clog2(N);
  typedef enum logic {ACQUIRE, TRACK} avg_state_t;
  avg_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [SW-1:0] sum_q, sum_d;
  logic [W-1:0] avg_d;
  logic avg_valid_d;
  logic signed [W+1:0] diff;
  logic signed [W+1:0] lim;
  logic signed [W+1:0] step;
  logic [SW-1:0] sum_new;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sum_d = sum_q;
    avg_d = avg_q;
    avg_valid_d = avg_valid_q;
    diff = $signed({2'b00, sample}) - $signed({2'b00, avg_q});
    lim = $signed({{(W-1){1'b0}}, 3'h0}) + (W+2)'((1 << clamp_code) - 1);
    // clamp magnitude before scaling, so the step never exceeds the limit
    if (clamp_code != 3'h0) begin
      if (diff > lim) begin
        diff = lim;
      end else if (diff < -lim) begin
        diff = -lim;
      end
    end
    // equation choice acts only once tracking, never during acquisition
    step = quarter_sel ? (diff >>> cfg_pkg::SHIFT_QUARTER) : (diff >>> cfg_pkg::SHIFT_SIXTEENTH);
    sum_new = sum_q + SW'(sample);
    if (!enable) begin
      state_d = ACQUIRE;
      cnt_d = '0;
      sum_d = '0;
      avg_valid_d = 1'b0;
    end else if (sample_valid) begin
      case (state_q)
        ACQUIRE: begin
          sum_d = sum_new;
          cnt_d = cnt_q + CW'(1);
          if (cnt_q == CW'(N - 1)) begin
            avg_d = W'(sum_new >> $clog2(N));
            avg_valid_d = 1'b1;
            state_d = TRACK;
          end
        end
        TRACK: begin
          avg_d = W'($signed({2'b00, avg_q}) + step);
        end
        default: state_d = ACQUIRE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ACQUIRE;
      cnt_q <= '0;
      sum_q <= '0;
      avg_q <= '0;
      avg_valid_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sum_q <= sum_d;
      avg_q <= avg_d;
      avg_valid_q <= avg_valid_d;
    end
  end
endmodule
`default_nettype wire
